// >>> src/pcr_pkg.sv
package pcr_pkg;

    // ------------------------------------------------------------
    // Local register port layout
    // ------------------------------------------------------------
    localparam int          PCR_ADDR_W       = 3;            // Local word index width
    localparam int          PCR_DATA_W       = 32;           // Register data width
    localparam logic [2:0]  PCR_IDX_CMD_STS  = 3'h0;         // Command status register
    localparam logic [2:0]  PCR_IDX_BAR5     = 3'h1;         // BAR5 / BAR5 mask shared slot
    localparam logic [2:0]  PCR_IDX_ERR_CTL  = 3'h2;         // Sticky error control
    localparam logic [2:0]  PCR_IDX_ERR_STS  = 3'h3;         // Sticky error status (W1C)
    localparam logic [2:0]  PCR_IDX_DEV_CTL  = 3'h4;         // Non-sticky device control
    localparam int          PCR_SHADOW_BIT   = 5;            // Shadow-write enable position

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] PCR_RST_CMD_STS  = 32'h0000_0000;
    localparam logic [31:0] PCR_RST_BAR5     = 32'h0000_0000;
    localparam logic [31:0] PCR_RST_BAR5_MSK = 32'h0000_0000; // Zero mask: window disabled
    localparam logic [31:0] PCR_RST_ERR_CTL  = 32'h0000_0000;
    localparam logic [31:0] PCR_RST_ERR_STS  = 32'h0000_0000;
    localparam logic [31:0] PCR_RST_DEV_CTL  = 32'h0000_0000;
    localparam logic [31:0] PCR_BAR5_ATTR    = 32'h0000_000F; // Low attribute bits read-only

endpackage : pcr_pkg

// >>> src/pcr_sticky_reg.sv
`timescale 1ns/100ps
`default_nettype none

// Sticky register: only a hard reset clears it
module pcr_sticky_reg
    import pcr_pkg::*;
#(
    parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_we,
    input  wire logic [31:0] i_wdata,
    input  wire logic [31:0] i_set,
    input  wire logic        i_w1c,
    output logic      [31:0] o_q
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] val_ff;   // Held value
    logic [31:0] nxt_val;  // Next value
    logic [31:0] w1c_data; // Value after a software write

    // Set wins over a clear in the same cycle
    assign w1c_data = i_w1c ? (val_ff & ~i_wdata) : i_wdata;
    assign nxt_val  = (i_we ? w1c_data : val_ff) | i_set;
    assign o_q      = val_ff;

    // Hard reset is the sole clear; soft and hot resets never reach here
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            val_ff <= RST_VAL;
        end else begin
            val_ff <= nxt_val;
        end
    end

endmodule // pcr_sticky_reg

`default_nettype wire

// >>> src/pcr_cfg_regs.sv
// Operation
// - BAR5 window disabled until mask programmed
// - Sticky bits survive hot reset
// - Sticky bits survive soft reset
// - Soft reset restores non-sticky bits
// - Hard reset clears sticky and non-sticky
`timescale 1ns/100ps
`default_nettype none

module pcr_cfg_regs
    import pcr_pkg::*;
(
    input  wire logic                  i_sys_clk,      // 50 MHz system clock
    input  wire logic                  i_sys_rst,      // Hard reset, async high
    input  wire logic                  i_soft_rst,     // Soft reset, sync pulse
    input  wire logic                  i_hot_rst,      // Hot reset from link, sync pulse
    input  wire logic                  i_endpoint_role,// High when acting as endpoint
    input  wire logic                  i_loc_we,       // Local write strobe
    input  wire logic                  i_loc_re,       // Local read strobe
    input  wire logic [PCR_ADDR_W-1:0] i_loc_addr,     // Local word index
    input  wire logic [31:0]           i_loc_wdata,    // Local write data
    input  wire logic                  i_lnk_we,       // Link-side write strobe
    input  wire logic [PCR_ADDR_W-1:0] i_lnk_addr,     // Link-side word index
    input  wire logic [31:0]           i_lnk_wdata,    // Link-side write data
    input  wire logic [31:0]           i_err_event,    // Error events into sticky status
    output logic      [31:0]           o_loc_rdata,    // Local read data
    output logic                       o_loc_rvalid,   // Read data valid pulse
    output logic      [31:0]           o_bar5_mask,    // Effective BAR5 mask
    output logic                       o_bar5_en,      // BAR5 window enabled
    output logic                       o_shadow_write_enable // Shadow bit state
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] cmd_sts_ff;   // Non-sticky command status
    logic [31:0] bar5_ff;      // Non-sticky BAR5 base
    logic [31:0] bar5_msk_ff;  // BAR5 mask, non-sticky
    logic [31:0] dev_ctl_ff;   // Non-sticky device control
    logic [31:0] err_ctl_q;    // Sticky error control
    logic [31:0] err_sts_q;    // Sticky error status
    logic [31:0] rdata_ff;     // Read data register
    logic        rvalid_ff;    // Read valid register

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire         shadow_on  = cmd_sts_ff[PCR_SHADOW_BIT];
    wire         wr_cmd     = i_loc_we && (i_loc_addr == PCR_IDX_CMD_STS);
    wire         wr_bar5_sl = i_loc_we && (i_loc_addr == PCR_IDX_BAR5);
    // Shadow bit steers the shared slot
    wire         wr_msk     = wr_bar5_sl && shadow_on;
    wire         wr_bar     = wr_bar5_sl && !shadow_on;
    // Link writes to BAR5 hit the base, never the mask
    wire         lnk_bar    = i_lnk_we && (i_lnk_addr == PCR_IDX_BAR5);
    wire         wr_dev     = i_loc_we && (i_loc_addr == PCR_IDX_DEV_CTL);
    wire         wr_ectl    = i_loc_we && (i_loc_addr == PCR_IDX_ERR_CTL);
    wire         wr_ests    = i_loc_we && (i_loc_addr == PCR_IDX_ERR_STS);
    // Soft and hot resets reinitialise only non-sticky state
    wire         nst_clr    = i_soft_rst || i_hot_rst;
    wire [31:0]  bar5_wval  = (lnk_bar ? i_lnk_wdata : i_loc_wdata) & ~PCR_BAR5_ATTR;
    wire [31:0]  bar5_rd    = shadow_on ? bar5_msk_ff : (bar5_ff | PCR_BAR5_ATTR);
    wire [31:0]  rd_mux     =
        (i_loc_addr == PCR_IDX_CMD_STS) ? cmd_sts_ff :
        (i_loc_addr == PCR_IDX_BAR5)    ? bar5_rd    :
        (i_loc_addr == PCR_IDX_ERR_CTL) ? err_ctl_q  :
        (i_loc_addr == PCR_IDX_ERR_STS) ? err_sts_q  :
        (i_loc_addr == PCR_IDX_DEV_CTL) ? dev_ctl_ff : 32'h0000_0000;
    // Zero mask means a disabled window; boot leaves it zero
    wire         nxt_bar5_en = i_endpoint_role && (bar5_msk_ff != 32'h0000_0000);

    // ------------------------------------------------------------
    // Non-sticky registers
    // ------------------------------------------------------------
    // Soft/hot reset beats a same-cycle write: reset is the stronger event
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cmd_sts_ff  <= PCR_RST_CMD_STS;
            bar5_ff     <= PCR_RST_BAR5;
            bar5_msk_ff <= PCR_RST_BAR5_MSK;
            dev_ctl_ff  <= PCR_RST_DEV_CTL;
        end else if (nst_clr) begin
            cmd_sts_ff  <= PCR_RST_CMD_STS;
            bar5_ff     <= PCR_RST_BAR5;
            bar5_msk_ff <= PCR_RST_BAR5_MSK;
            dev_ctl_ff  <= PCR_RST_DEV_CTL;
        end else begin
            if (wr_cmd) begin
                cmd_sts_ff <= i_loc_wdata;
            end
            if (wr_bar || lnk_bar) begin
                bar5_ff <= bar5_wval;
            end
            if (wr_msk) begin
                bar5_msk_ff <= i_loc_wdata;
            end
            if (wr_dev) begin
                dev_ctl_ff <= i_loc_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky registers: no soft or hot reset input at all
    // ------------------------------------------------------------
    pcr_sticky_reg #(
        .RST_VAL (PCR_RST_ERR_CTL)
    ) u_err_ctl (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_we      (wr_ectl),
        .i_wdata   (i_loc_wdata),
        .i_set     (32'h0000_0000),
        .i_w1c     (1'b0),
        .o_q       (err_ctl_q)
    );

    pcr_sticky_reg #(
        .RST_VAL (PCR_RST_ERR_STS)
    ) u_err_sts (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_we      (wr_ests),
        .i_wdata   (i_loc_wdata),
        .i_set     (i_err_event),
        .i_w1c     (1'b1),
        .o_q       (err_sts_q)
    );

    // ------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_ff              <= 32'h0000_0000;
            rvalid_ff             <= 1'b0;
            o_bar5_mask           <= PCR_RST_BAR5_MSK;
            o_bar5_en             <= 1'b0;
            o_shadow_write_enable <= 1'b0;
        end else begin
            rdata_ff              <= i_loc_re ? rd_mux : 32'h0000_0000;
            rvalid_ff             <= i_loc_re;
            o_bar5_mask           <= bar5_msk_ff;
            o_bar5_en             <= nxt_bar5_en;
            o_shadow_write_enable <= shadow_on;
        end
    end

    assign o_loc_rdata  = rdata_ff;
    assign o_loc_rvalid = rvalid_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sticky_hot_keep: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_hot_rst || i_soft_rst) && !i_loc_we && i_err_event == 32'h0000_0000
        |=> err_sts_q == $past(err_sts_q) && err_ctl_q == $past(err_ctl_q))
        else $error("sticky bits changed on soft or hot reset");

    a_soft_clr_nst: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_soft_rst |=> cmd_sts_ff == PCR_RST_CMD_STS && bar5_msk_ff == PCR_RST_BAR5_MSK
        ##1 o_bar5_en == 1'b0)
        else $error("non-sticky bits not restored by soft reset");

    a_mask_gated_wr: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        wr_bar5_sl && !shadow_on && !nst_clr |=> bar5_msk_ff == $past(bar5_msk_ff))
        else $error("mask changed without shadow enable");

    a_mask_takes_wr: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        wr_msk && !nst_clr |=> bar5_msk_ff == $past(i_loc_wdata)
        ##1 o_bar5_mask == $past(bar5_msk_ff))
        else $error("shadow mask write lost");

    a_link_no_mask: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        lnk_bar && !wr_msk |=> bar5_msk_ff == $past(bar5_msk_ff) || $past(nst_clr))
        else $error("link write reached the mask");

    a_bar5_off_zero: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        bar5_msk_ff == 32'h0000_0000 |=> !o_bar5_en)
        else $error("BAR5 enabled with zero mask");

    a_err_set_wins: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_err_event != 32'h0000_0000 |=> (err_sts_q & $past(i_err_event)) == $past(i_err_event))
        else $error("error event lost");

    a_rd_one_cycle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_loc_re && i_loc_addr == PCR_IDX_ERR_STS |=> o_loc_rvalid && o_loc_rdata == $past(err_sts_q))
        else $error("read data mismatch");

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // High from a hard reset until the first clean edge after release;
    // lets a check see reset values without sampling the async pin itself
    logic        hard_seen_ff; // Hard reset seen since the last edge
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hard_seen_ff <= 1'b1;
        end else begin
            hard_seen_ff <= 1'b0;
        end
    end

    // No disable here: this one must look inside and just after hard reset
    a_hard_clr_all: assert property (@(posedge i_sys_clk)
        hard_seen_ff |-> err_ctl_q == PCR_RST_ERR_CTL && err_sts_q == PCR_RST_ERR_STS
        && cmd_sts_ff == PCR_RST_CMD_STS && bar5_msk_ff == PCR_RST_BAR5_MSK
        && dev_ctl_ff == PCR_RST_DEV_CTL && bar5_ff == PCR_RST_BAR5)
        else $error("hard reset left a register set");

    // Hot reset takes the same path as soft reset for non-sticky state
    a_hot_clr_nst: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_hot_rst |=> cmd_sts_ff == PCR_RST_CMD_STS && bar5_ff == PCR_RST_BAR5
        && dev_ctl_ff == PCR_RST_DEV_CTL && bar5_msk_ff == PCR_RST_BAR5_MSK)
        else $error("non-sticky bits not restored by hot reset");

    a_soft_keep_ctl: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_soft_rst && !wr_ectl |=> err_ctl_q == $past(err_ctl_q))
        else $error("sticky control changed on soft reset");

endmodule // pcr_cfg_regs

`default_nettype wire

// >>> testbench/pcr_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Link-side partner: issues one config write per request pulse
module pcr_host_model
    import pcr_pkg::*;
(
    input  wire logic                  i_sys_clk,   // System clock
    input  wire logic                  i_req,       // Request one link write
    input  wire logic [PCR_ADDR_W-1:0] i_addr,      // Word index to write
    input  wire logic [31:0]           i_data,      // Data to write
    output logic                       o_lnk_we,    // Link write strobe
    output logic      [PCR_ADDR_W-1:0] o_lnk_addr,  // Link word index
    output logic      [31:0]           o_lnk_wdata  // Link write data
);
    // ------------------------------------------------------------
    // Write driver
    // ------------------------------------------------------------
    initial begin
        o_lnk_we    = 1'b0;
        o_lnk_addr  = '0;
        o_lnk_wdata = 32'h0000_0000;
    end
    // Only base writes are sent by the bench; masks are local-only
    always @(posedge i_sys_clk) begin
        if (i_req) begin
            #1 o_lnk_we = 1'b1;
            o_lnk_addr  = i_addr;
            o_lnk_wdata = i_data;
            @(posedge i_sys_clk);
            #1 o_lnk_we = 1'b0;
            // Idle data toggles so a stale value is never mistaken for valid
            o_lnk_wdata = ~o_lnk_wdata;
        end
    end
endmodule // pcr_host_model

`default_nettype wire

// >>> testbench/pcie_ep_config_reset_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH %s exp=%h got=%h", nm, exp, got); end end

module pcie_ep_config_reset_regs_tb_top;
    import pcr_pkg::*;
    // ------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------
    logic        sys_clk = 0, sys_rst = 1, soft_rst = 0, hot_rst = 0, ep = 1;
    logic        loc_we = 0, loc_re = 0, host_req = 0, lnk_we, rvalid, bar5_en, shadow;
    logic [2:0]  loc_addr = '0, host_addr = '0, lnk_addr;
    logic [31:0] loc_wdata = '0, host_data = '0, lnk_wdata, err_ev = '0, rdata, mask;
    int          num_errors = 0, compares = 0, cycles = 0;
    localparam logic [31:0] BASE_RD = PCR_RST_BAR5 | PCR_BAR5_ATTR; // Base as read after reset

    always #10 sys_clk = ~sys_clk;   // 50 MHz

    pcr_cfg_regs dut (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_soft_rst(soft_rst),
        .i_hot_rst(hot_rst), .i_endpoint_role(ep), .i_loc_we(loc_we), .i_loc_re(loc_re),
        .i_loc_addr(loc_addr), .i_loc_wdata(loc_wdata), .i_lnk_we(lnk_we),
        .i_lnk_addr(lnk_addr), .i_lnk_wdata(lnk_wdata), .i_err_event(err_ev),
        .o_loc_rdata(rdata), .o_loc_rvalid(rvalid), .o_bar5_mask(mask),
        .o_bar5_en(bar5_en), .o_shadow_write_enable(shadow));
    pcr_host_model host (.i_sys_clk(sys_clk), .i_req(host_req), .i_addr(host_addr),
        .i_data(host_data), .o_lnk_we(lnk_we), .o_lnk_addr(lnk_addr), .o_lnk_wdata(lnk_wdata));

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge sys_clk); #1 loc_we = 1; loc_addr = a; loc_wdata = d;
        @(posedge sys_clk); #1 loc_we = 0; loc_wdata = ~d;
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] exp, input string nm);
        @(posedge sys_clk); #1 loc_re = 1; loc_addr = a;
        @(posedge sys_clk); #1 loc_re = 0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK(nm, exp, rdata)
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        @(posedge sys_clk); #1 s = 1;
        @(posedge sys_clk); #1 s = 0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_boot();   // Window closed with untouched mask
        settle();
        `CHK("boot_en", 1'b0, bar5_en)
        `CHK("boot_mask", PCR_RST_BAR5_MSK, mask)
    endtask
    task automatic t_mask();   // Shadow-gated mask programming
        wr(PCR_IDX_BAR5, 32'hFFFF_0000); settle();
        `CHK("mask_unshadowed", 32'h0000_0000, mask)
        rd(PCR_IDX_BAR5, 32'hFFFF_000F, "base_rd");
        ep = 0;
        wr(PCR_IDX_CMD_STS, 32'h0000_0020); wr(PCR_IDX_BAR5, 32'h00FF_F000); settle();
        `CHK("shadow_on", 1'b1, shadow)
        `CHK("mask_set", 32'h00FF_F000, mask)
        `CHK("en_not_ep", 1'b0, bar5_en)
        rd(PCR_IDX_BAR5, 32'h00FF_F000, "mask_rd");
        ep = 1; settle();
        `CHK("en_ep", 1'b1, bar5_en)
        wr(PCR_IDX_CMD_STS, 32'h0000_0000); settle();
        `CHK("shadow_off", 1'b0, shadow)
        rd(PCR_IDX_BAR5, 32'hFFFF_000F, "base_back");
    endtask
    task automatic t_link();   // Link write with shadow set still misses mask
        wr(PCR_IDX_CMD_STS, 32'h0000_0020);
        host_addr = PCR_IDX_BAR5; host_data = 32'h1234_5670; pulse(host_req); settle();
        `CHK("lnk_mask", 32'h00FF_F000, mask)
        wr(PCR_IDX_CMD_STS, 32'h0000_0000);
        rd(PCR_IDX_BAR5, 32'h1234_567F, "lnk_base");
    endtask
    task automatic t_sticky(ref logic r, input string nm);   // Hot or soft reset
        wr(PCR_IDX_ERR_CTL, 32'hA5A5_0001); wr(PCR_IDX_DEV_CTL, 32'h0000_00FF);
        @(posedge sys_clk); #1 err_ev = 32'h0000_0008;
        @(posedge sys_clk); #1 err_ev = 32'h0000_0000;
        pulse(r);
        rd(PCR_IDX_ERR_CTL, 32'hA5A5_0001, {nm, "_errctl"});
        rd(PCR_IDX_ERR_STS, 32'h0000_0008, {nm, "_errsts"});
        rd(PCR_IDX_DEV_CTL, PCR_RST_DEV_CTL, {nm, "_devctl"});
        rd(PCR_IDX_BAR5, BASE_RD, {nm, "_base"});
        wr(PCR_IDX_ERR_STS, 32'h0000_0008);
        rd(PCR_IDX_ERR_STS, 32'h0000_0000, {nm, "_w1c"});
    endtask
    task automatic t_hard();   // Hard reset clears sticky too
        wr(PCR_IDX_ERR_CTL, 32'h0000_0F0F); wr(PCR_IDX_DEV_CTL, 32'h0000_0001);
        @(posedge sys_clk); #1 sys_rst = 1;
        repeat (2) @(posedge sys_clk); #1 sys_rst = 0;
        rd(PCR_IDX_ERR_CTL, PCR_RST_ERR_CTL, "hard_errctl");
        rd(PCR_IDX_DEV_CTL, PCR_RST_DEV_CTL, "hard_devctl");
        rd(PCR_IDX_CMD_STS, PCR_RST_CMD_STS, "hard_cmd");
    endtask

    // ------------------------------------------------------------
    // Verdict and watchdog
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks=%0d errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Whole run needs well under 1000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles >= 5000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 sys_rst = 0;
        t_boot(); t_mask(); t_link();
        t_sticky(hot_rst, "hot"); t_sticky(soft_rst, "soft");
        t_hard();
        complete_run();
    end
endmodule // pcie_ep_config_reset_regs_tb_top

`default_nettype wire
